// *** src/ldd_pkg.sv ***
package ldd_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_DUTY0 = 8'h00;
  localparam logic [7:0] ADDR_DUTY1 = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_DERATE = 8'h10;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int CFG_MULT_LSB = 0;
  localparam int CFG_MULT_W = 3;
  localparam int CFG_BATDIS_BIT = 3;
  localparam int STAT_TWARN_BIT = 0;
  localparam int STAT_TLIVE_BIT = 1;
  localparam logic [2:0] RST_MULT = 3'h1;
  localparam logic RST_BATDIS = 1'b0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_NS = 10_000;
  localparam int TICK_CYC = TICK_NS / 20;
  localparam int LONG_ONE_US = 40_000;
  localparam int LONG_ONE_TICKS = LONG_ONE_US / 10;
  localparam int LONG_ZERO_US = 2_000;
  localparam int LONG_ZERO_TICKS = LONG_ZERO_US / 10;
  localparam int INT_HZ = 500;
  localparam int INT_TICKS = (1_000_000 / INT_HZ) / 10;

  // ----------------------------------------------------------------------
  // Derating factors in 1/256 units
  // ----------------------------------------------------------------------
  localparam logic [8:0] F_UNITY = 9'h100;
  localparam logic [8:0] F_THERM = 9'h0C0;
  localparam logic [8:0] F_BAT_6_7 = 9'h0DC;
  localparam logic [8:0] F_BAT_LOW = 9'h080;
  localparam logic [8:0] F_BAT_7_8 = 9'h0F0;
  localparam logic [7:0] BAT_6V = 8'h3C;
  localparam logic [7:0] BAT_7V = 8'h46;
  localparam logic [7:0] BAT_8V = 8'h50;
  localparam logic [7:0] DUTY_OFF = 8'hFF;

  typedef enum logic [2:0]
  {
    CH_LOW = 3'b001,
    CH_HIGH = 3'b010,
    CH_FULL = 3'b100
  } ldd_mode_t;

endpackage

// *** src/ldd_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldd_channel
  import ldd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic dimming_input,
  input wire logic [7:0] channel_duty_code,
  input wire logic [2:0] freq_multiplier,
  input wire logic [8:0] shared_derating_factor,
  output logic channel_switch_enable
);

  // ----------------------------------------------------------------------
  // Input measurement
  // ----------------------------------------------------------------------
  logic in_d_ff;
  logic [15:0] hi_cnt_ff, per_cnt_ff;
  logic [15:0] hi_meas_ff, per_meas_ff;
  ldd_mode_t mode_ff;
  logic rise;
  assign rise = tick && dimming_input && !in_d_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_d_ff <= 1'b0;
      hi_cnt_ff <= 16'h0000;
      per_cnt_ff <= 16'h0000;
      hi_meas_ff <= 16'h0000;
      per_meas_ff <= 16'h0000;
      mode_ff <= CH_LOW;
    end
    else if (tick)
    begin
      in_d_ff <= dimming_input;
      if (rise)
      begin
        per_meas_ff <= per_cnt_ff;
        hi_meas_ff <= hi_cnt_ff;
        per_cnt_ff <= 16'h0001;
        hi_cnt_ff <= 16'h0001;
        mode_ff <= CH_HIGH;
      end
      else
      begin
        if (per_cnt_ff != 16'hFFFF)
          per_cnt_ff <= per_cnt_ff + 16'h0001;
        if (dimming_input && hi_cnt_ff != 16'hFFFF)
          hi_cnt_ff <= hi_cnt_ff + 16'h0001;
        // Long one with no falling edge means full duty
        if (dimming_input && hi_cnt_ff > 16'(LONG_ONE_TICKS))
          mode_ff <= CH_FULL;
        // Low for long enough means zero duty
        if (!dimming_input && per_cnt_ff - hi_cnt_ff
            >= 16'(LONG_ZERO_TICKS))
          mode_ff <= CH_LOW;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output period generation
  // ----------------------------------------------------------------------
  logic [15:0] out_cnt_ff, out_per_ff, out_on_ff;
  logic [15:0] src_per, src_hi;
  logic [31:0] on_calc;
  logic [8:0] duty_f;
  logic en_ff;

  // Codes map 0..254 to factor 256..2 in 1/256 units and 255 to zero, close to (255-c)/255
  assign duty_f = (channel_duty_code == DUTY_OFF) ? 9'h000 :
                  9'(9'h100 - {1'b0, channel_duty_code});
  always_comb
  begin
    if (mode_ff == CH_FULL)
    begin
      src_per = 16'(INT_TICKS);
      src_hi = 16'(INT_TICKS);
    end
    else
    begin
      src_per = per_meas_ff;
      src_hi = (mode_ff == CH_LOW) ? 16'h0000 : hi_meas_ff;
    end
    on_calc = (32'(src_hi) * 32'(duty_f) * 32'(shared_derating_factor))
              >> 16;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_cnt_ff <= 16'h0000;
      out_per_ff <= 16'h0000;
      out_on_ff <= 16'h0000;
      en_ff <= 1'b0;
    end
    else if (tick)
    begin
      if (out_cnt_ff + 16'h0001 >= out_per_ff)
      begin
        // New settings latch only at a period boundary
        out_cnt_ff <= 16'h0000;
        // Zero period would stall the counter, so floor it at one tick
        out_per_ff <= ((src_per >> freq_multiplier) == 16'h0000) ? 16'h0001
                      : (src_per >> freq_multiplier);
        out_on_ff <= 16'(on_calc >> freq_multiplier);
      end
      else
        out_cnt_ff <= out_cnt_ff + 16'h0001;
      en_ff <= (out_cnt_ff < out_on_ff) && (duty_f != 9'h000);
    end
    // Off code acts at once, not only at the next tick
    if (duty_f == 9'h000)
      en_ff <= 1'b0;
  end
  assign channel_switch_enable = en_ff;

  property p_off_code;
    @(posedge aclk) disable iff (!aresetn)
    $past(channel_duty_code) == DUTY_OFF |-> !en_ff;
  endproperty
  a_off_code: assert property (p_off_code)
    else $error("enable on with off code");

endmodule
`default_nettype wire

// *** src/ldd_top.sv ***
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ldd_top
  import ldd_pkg::*;
#(
  parameter logic [7:0] OTP_DUTY0 = 8'h00,
  parameter logic [7:0] OTP_DUTY1 = 8'h00
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] dimming_input,
  input wire logic [7:0] battery_supply_pin,
  input wire logic thermal_warning,
  output logic [1:0] channel_switch_enable,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------------
  logic [9:0] div_ff;
  logic tick_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_ff <= 10'h000;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (div_ff == 10'(TICK_CYC - 1));
      div_ff <= (div_ff == 10'(TICK_CYC - 1)) ? 10'h000 : div_ff + 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] duty_ff [2];
  logic [2:0] mult_ff;
  logic batdis_ff, twarn_ff;
  logic aw_ff, w_ff, awready_ff, wready_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff, arready_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic do_wr, rd_take, stat_read;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_DUTY0) || (a == ADDR_DUTY1) || (a == ADDR_CFG)
              || (a == ADDR_STATUS) || (a == ADDR_DERATE);
  endfunction

  assign do_wr = aw_ff && w_ff && !bvalid_ff;
  assign rd_take = s_axi_arvalid && arready_ff;
  assign stat_read = rd_take && s_axi_araddr == ADDR_STATUS;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && !aw_ff)
      begin
        aw_ff <= 1'b1;
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ff)
      begin
        w_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= addr_ok(awaddr_ff) ? 2'h0 : 2'h3;
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end
  // Ready copies of the hold flags keep the bus outputs registered
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;

  // Startup duty code is the one-time programmed value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      duty_ff[0] <= OTP_DUTY0;
      duty_ff[1] <= OTP_DUTY1;
      mult_ff <= RST_MULT;
      batdis_ff <= RST_BATDIS;
    end
    else if (do_wr && wstrb_ff[0])
    begin
      if (awaddr_ff == ADDR_DUTY0)
        duty_ff[0] <= wdata_ff[7:0];
      if (awaddr_ff == ADDR_DUTY1)
        duty_ff[1] <= wdata_ff[7:0];
      if (awaddr_ff == ADDR_CFG)
      begin
        mult_ff <= wdata_ff[CFG_MULT_LSB +: CFG_MULT_W];
        batdis_ff <= wdata_ff[CFG_BATDIS_BIT];
      end
    end
  end

  // Sticky warning; a new warning beats the clear of the read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      twarn_ff <= 1'b0;
    else if (thermal_warning)
      twarn_ff <= 1'b1;
    else if (stat_read)
      twarn_ff <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Derating
  // ----------------------------------------------------------------------
  logic [8:0] bat_f, therm_f, drf_ff;
  logic [17:0] prod;
  always_comb
  begin
    if (batdis_ff || battery_supply_pin >= BAT_8V)
      bat_f = F_UNITY;
    else if (battery_supply_pin >= BAT_7V)
      bat_f = F_BAT_7_8;
    else if (battery_supply_pin >= BAT_6V)
      bat_f = F_BAT_6_7;
    else
      bat_f = F_BAT_LOW;
    // Live input, so derating leaves with the warning
    therm_f = thermal_warning ? F_THERM : F_UNITY;
    prod = 18'(bat_f) * 18'(therm_f);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      drf_ff <= F_UNITY;
    else
      drf_ff <= prod[16:8];
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end
    else if (rd_take)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= addr_ok(s_axi_araddr) ? 2'h0 : 2'h3;
      unique case (1'b1)
        s_axi_araddr == ADDR_DUTY0: rdata_ff <= {24'h000000, duty_ff[0]};
        s_axi_araddr == ADDR_DUTY1: rdata_ff <= {24'h000000, duty_ff[1]};
        s_axi_araddr == ADDR_CFG:
          rdata_ff <= {28'h0000000, batdis_ff, mult_ff};
        s_axi_araddr == ADDR_STATUS:
          rdata_ff <= {30'h00000000, thermal_warning,
                       twarn_ff | thermal_warning};
        s_axi_araddr == ADDR_DERATE: rdata_ff <= {23'h000000, drf_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      ldd_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_ff),
        .dimming_input(dimming_input[gi]),
        .channel_duty_code(duty_ff[gi]),
        .freq_multiplier(mult_ff),
        .shared_derating_factor(drf_ff),
        .channel_switch_enable(channel_switch_enable[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_tick_period;
    @(posedge aclk) disable iff (!aresetn)
    tick_ff |=> !tick_ff [*8];
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick too frequent");

  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
    thermal_warning |=> twarn_ff;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("warning not latched");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    stat_read && !thermal_warning |=> !twarn_ff;
  endproperty
  a_clear: assert property (p_clear)
    else $error("warning not cleared");

  property p_therm;
    @(posedge aclk) disable iff (!aresetn)
    thermal_warning && (batdis_ff || battery_supply_pin >= BAT_8V)
      && $stable(thermal_warning) && $stable(batdis_ff)
    |=> drf_ff == F_THERM;
  endproperty
  a_therm: assert property (p_therm)
    else $error("thermal factor wrong");

  property p_unity;
    @(posedge aclk) disable iff (!aresetn)
    !thermal_warning && batdis_ff |=> drf_ff == F_UNITY;
  endproperty
  a_unity: assert property (p_unity)
    else $error("factor not unity");

  property p_resp;
    @(posedge aclk) disable iff (!aresetn)
    do_wr |=> s_axi_bvalid;
  endproperty
  a_resp: assert property (p_resp)
    else $error("no write response");

  property p_rd;
    @(posedge aclk) disable iff (!aresetn)
    rd_take |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd)
    else $error("no read response");

  property p_bat67;
    @(posedge aclk) disable iff (!aresetn)
    !thermal_warning && !batdis_ff && battery_supply_pin >= BAT_6V
      && battery_supply_pin < BAT_7V |=> drf_ff == F_BAT_6_7;
  endproperty
  a_bat67: assert property (p_bat67)
    else $error("battery factor wrong");

  property p_bat_therm;
    @(posedge aclk) disable iff (!aresetn)
    thermal_warning && !batdis_ff && battery_supply_pin >= BAT_6V
      && battery_supply_pin < BAT_7V
    |=> drf_ff == 9'((18'(F_BAT_6_7) * 18'(F_THERM)) >> 8);
  endproperty
  a_bat_therm: assert property (p_bat_therm)
    else $error("combined factor wrong");

  c_write: cover property (@(posedge aclk) do_wr);
  c_therm: cover property (@(posedge aclk) thermal_warning && !batdis_ff);
  c_warn: cover property (@(posedge aclk) stat_read && twarn_ff);
  c_en: cover property (@(posedge aclk) channel_switch_enable[0]);

endmodule
`default_nettype wire

// *** dv/ldd_dim_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldd_dim_src
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [1:0] level,
  output logic [1:0] dimming_input
);
  // ----------------------------------------
  // Dimming source for both channels
  // ----------------------------------------
  // Edges stay on the 10 us grid so the sampler sees whole ticks
  localparam int PER_CYC = 10_000;
  localparam int HIGH_CYC = 5_000;
  int cnt_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      cnt_ff <= 0;
    else if (cnt_ff == PER_CYC - 1)
      cnt_ff <= 0;
    else
      cnt_ff <= cnt_ff + 1;
  end

  // Static level outside PWM runs
  assign dimming_input = run ? {2{cnt_ff < HIGH_CYC}} : level;
endmodule
`default_nettype wire

// *** dv/ldd_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module ldd_top_test;
  import ldd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic run = 1'b0;
  logic [1:0] level = 2'h0;
  logic [1:0] dimming_input;
  logic [7:0] battery_supply_pin = 8'h5A;
  logic thermal_warning = 1'b0;
  logic [1:0] channel_switch_enable;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [8:0] bat_exp [4] = '{9'h100, 9'h0F0, 9'h0DC, 9'h080};
  logic [7:0] bat_in [4] = '{8'h5A, 8'h4B, 8'h41, 8'h30};
  int hi0;
  int hi1;
  int rise1;
  logic prev1;

  always #10 aclk = ~aclk;

  ldd_top #(.OTP_DUTY0(8'h12), .OTP_DUTY1(8'h34)) ldd_top_i (
    .aclk(aclk), .aresetn(aresetn), .dimming_input(dimming_input),
    .battery_supply_pin(battery_supply_pin),
    .thermal_warning(thermal_warning),
    .channel_switch_enable(channel_switch_enable),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  ldd_dim_src ldd_dim_src_i (
    .aclk(aclk), .aresetn(aresetn), .run(run), .level(level),
    .dimming_input(dimming_input));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
  begin
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask

  task automatic give_verdict;
  begin
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // Ceiling covers register work plus six input periods
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 95_000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
  begin
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
  end
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ar_ok;
  begin
    ar_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (!ar_ok && arready)
      begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
  end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
  begin
    rdr(a, rd, rsp);
    chk(nm, rd, exp);
  end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk("en_reset", {30'h0, channel_switch_enable}, 32'h0);
    rchk("duty0_start", ADDR_DUTY0, 32'h12);
    rchk("duty1_start", ADDR_DUTY1, 32'h34);
    rchk("cfg_reset", ADDR_CFG, {28'h0, RST_BATDIS, RST_MULT});
    rdr(8'h14, rd, rsp);
    chk("unmapped_rresp", {30'h0, rsp}, 32'h3);
    chk("unmapped_rdata", rd, 32'h0);
    wr(8'h20, 32'h5, rsp);
    chk("unmapped_bresp", {30'h0, rsp}, 32'h3);
    for (int m = 0; m < 8; m++)
    begin
      wr(ADDR_CFG, m, rsp);
      rchk("cfg_mult", ADDR_CFG, m);
    end
    for (int t = 0; t < 2; t++)
      for (int i = 0; i < 4; i++)
      begin
        battery_supply_pin <= bat_in[i];
        thermal_warning <= t[0];
        repeat (4) @(posedge aclk);
        rchk("derate", ADDR_DERATE,
             t ? (bat_exp[i] * F_THERM) >> 8 : bat_exp[i]);
      end
    wr(ADDR_CFG, 32'h9, rsp);
    chk("cfg_bresp", {30'h0, rsp}, 32'h0);
    repeat (4) @(posedge aclk);
    rchk("derate_batdis", ADDR_DERATE, F_THERM);
    rchk("stat_live", ADDR_STATUS, 32'h3);
    rchk("stat_set_wins", ADDR_STATUS, 32'h3);
    thermal_warning <= 1'b0;
    repeat (4) @(posedge aclk);
    rchk("derate_exit", ADDR_DERATE, F_UNITY);
    rchk("stat_sticky", ADDR_STATUS, 32'h1);
    rchk("stat_cleared", ADDR_STATUS, 32'h0);
    battery_supply_pin <= 8'h5A;
    wr(ADDR_CFG, 32'h1, rsp);
    wr(ADDR_DUTY0, DUTY_OFF, rsp);
    wr(ADDR_DUTY1, 32'h80, rsp);
    rchk("duty1_over", ADDR_DUTY1, 32'h80);
    run <= 1'b1;
    repeat (40_000) @(posedge aclk);
    hi0 = 0;
    hi1 = 0;
    rise1 = 0;
    prev1 = channel_switch_enable[1];
    repeat (20_000)
    begin
      @(posedge aclk);
      hi0 += channel_switch_enable[0] === 1'b1;
      hi1 += channel_switch_enable[1] === 1'b1;
      rise1 += (channel_switch_enable[1] === 1'b1 && prev1 === 1'b0);
      prev1 = channel_switch_enable[1];
    end
    chk("ch0_off", hi0, 0);
    chk("ch1_rises", rise1 inside {[3:5]}, 1);
    chk("ch1_duty", hi1 inside {[4000:6000]}, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
